//--- core/bus_cycle_pkg.sv
// shared constants and types for the local bus cycle controller
package bus_cycle_pkg;
   // reserved coprocessor i/o ports
   localparam logic [23:0] CP_PORT_CMD = 24'h0000f8;
   localparam logic [23:0] CP_PORT_DATA = 24'h0000fa;
   localparam logic [23:0] CP_PORT_STAT = 24'h0000fc;
   // prefetch queue geometry
   localparam int QUEUE_BYTES = 6;
   localparam logic [2:0] PF_MIN_FREE = 3'h2;
   // idle processor cycles between the two acknowledge operations
   localparam int INTERRUPT_ACK_CYCLE_GAP_CYC = 3;
   // clocks after reset release during which hold must stay low (far side)
   localparam int RESET_HOLD_CLKS = 34;
   // exception number raised past the code segment end
   localparam logic [7:0] EXC_GP = 8'h0d;
   // status line encodings, active low, cycle type shown only in the status state, STAT_NONE otherwise
   localparam logic [1:0] STAT_INTERRUPT_ACK_CYCLE = 2'h0;
   localparam logic [1:0] STAT_READ = 2'h1;
   localparam logic [1:0] STAT_WRITE = 2'h2;
   localparam logic [1:0] STAT_NONE = 2'h3;
   localparam logic [1:0] GAP_W = 2'h2;
   typedef enum logic [2:0] {
      s_idle, s_status, s_cmd, s_hold_ti, s_hold, s_gap
   } bus_state_t;
   typedef enum logic [2:0] {
      src_none, src_data, src_esc, src_cp, src_pf, src_interrupt_ack_cycle, src_hold
   } src_t;
endpackage

//--- core/bus_cycle_ctrl.sv
// local bus cycle controller: status/command, hold, lock, prefetch, coprocessor, acknowledge
`timescale 1ns/1ps
module bus_cycle_ctrl
   import bus_cycle_pkg::*;
#(
   parameter int QUEUE_SIZE = QUEUE_BYTES,
   parameter int GAP_CYCLES = INTERRUPT_ACK_CYCLE_GAP_CYC
)(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ready_b,
   input wire logic hold_req,
   input wire logic interrupt_request,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_io,
   input wire logic req_byte,
   input wire logic req_lock,
   input wire logic req_lock_drop,
   input wire logic [23:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic esc_valid,
   input wire logic esc_port_sel,
   input wire logic esc_write,
   input wire logic [15:0] esc_wdata,
   input wire logic coproc_operand_request,
   input wire logic coproc_escape_op,
   input wire logic cp_store,
   input wire logic [23:0] cp_mem_addr,
   input wire logic emulation_bit,
   input wire logic task_switched_bit,
   input wire logic [1:0] q_take,
   input wire logic ctl_xfer,
   input wire logic [23:0] ctl_target,
   input wire logic pf_halt_stop,
   input wire logic prot_mode,
   input wire logic [23:0] cs_last_addr,
   input wire logic exec_valid,
   input wire logic [23:0] exec_addr,
   input wire logic [15:0] data_in,
   output logic [23:0] bus_addr,
   output logic addr_oe,
   output logic [15:0] data_out,
   output logic data_oe,
   output logic [1:0] status_b,
   output logic status_oe,
   output logic mem_io,
   output logic interrupt_ack_cycle,
   output logic transfer_direction,
   output logic lock_b,
   output logic lock_oe,
   output logic hold_grant,
   output logic req_ready,
   output logic esc_ready,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic [15:0] fetch_data,
   output logic fetch_valid,
   output logic fetch_byte,
   output logic [7:0] vector,
   output logic vector_valid,
   output logic gp_fault
);

   generate
      if (QUEUE_SIZE < 2 || QUEUE_SIZE > 7) begin : g_bad_q
         $error("queue size must lie in 2..7");
      end
      if (GAP_CYCLES < 1 || GAP_CYCLES > 4) begin : g_bad_gap
         $error("gap cycles must lie in 1..4");
      end
   endgenerate

   bus_state_t state_ff, nxt_state;
   src_t sel, cur_src_ff;
   logic ph2_ff, lock_ff, first_tc_ff, inta2_ff, wr_tail_ff;
   logic cur_write_ff, cur_io_ff, cur_byte_ff, cur_drop_ff, cur_stale_ff, cur_hi_ff;
   logic [15:0] cur_wdata_ff, data_out_ff, cp_data_ff;
   logic [23:0] addr_ff, pf_addr_ff;
   logic [1:0] gap_cnt_ff, cp_step_ff;
   logic [2:0] q_cnt_ff;
   logic pf_stop_ff;

   // processor cycle ends on every phase-two clock
   wire adv = ph2_ff;
   wire cmd_end = state_ff == s_cmd && !ready_b;
   wire inta1_end = cmd_end && cur_src_ff == src_interrupt_ack_cycle && !inta2_ff;
   wire cyc_end = adv && cmd_end;
   wire free = adv && (state_ff == s_idle || (cmd_end && !inta1_end));
   wire gap_done = adv && state_ff == s_gap && gap_cnt_ff == 2'h0;

   // request qualification
   wire cp_ok = !emulation_bit && !task_switched_bit;
   wire cp_go = coproc_operand_request && coproc_escape_op && cp_ok;
   wire esc_go = esc_valid && cp_ok;
   wire [2:0] q_free = 3'(QUEUE_SIZE) - q_cnt_ff;
   wire pf_in_lim = !prot_mode || pf_addr_ff <= cs_last_addr;
   wire pf_go = !pf_stop_ff && q_free >= PF_MIN_FREE && pf_in_lim;

   // bus usage priority
   always_comb begin
      sel = src_none;
      if (lock_ff && req_valid) begin
         sel = src_data;
      end else if (cp_step_ff != 2'h0) begin
         sel = src_cp;
      end else if (hold_req && !lock_ff) begin
         sel = src_hold;
      end else if (interrupt_request && !lock_ff) begin
         sel = src_interrupt_ack_cycle;
      end else if (cp_go) begin
         sel = src_cp;
      end else if (esc_go) begin
         sel = src_esc;
      end else if (req_valid) begin
         sel = src_data;
      end else if (pf_go && !lock_ff) begin
         sel = src_pf;
      end
   end

   wire launch = free && sel != src_none && sel != src_hold;
   wire hold_go = free && sel == src_hold;
   assign req_ready = launch && sel == src_data;
   assign esc_ready = launch && sel == src_esc;

   // coprocessor operand step decode
   wire cp_odd = cp_mem_addr[0];
   wire [1:0] cp_mops = cp_odd ? 2'h2 : 2'h1;
   wire cp_port = cp_store ? cp_step_ff == 2'h0 : cp_step_ff == cp_mops;
   wire [1:0] cp_m = cp_store ? cp_step_ff - 2'h1 : cp_step_ff;
   wire cp_last = cp_step_ff == cp_mops;
   wire [23:0] cp_maddr = cp_mem_addr + {23'h0, cp_m[0]};
   wire [7:0] cp_bsel = cp_m[0] ? cp_data_ff[15:8] : cp_data_ff[7:0];
   wire [15:0] cp_wdata = (!cp_port && cp_odd) ? {cp_bsel, cp_bsel} : cp_data_ff;
   wire cp_wr = cp_port ? !cp_store : cp_store;

   // fields of the operation about to start
   wire is_d = sel == src_data;
   wire is_e = sel == src_esc;
   wire is_c = sel == src_cp;
   wire is_i = sel == src_interrupt_ack_cycle;
   wire nx_write = is_d ? req_write : is_e ? esc_write : is_c && cp_wr;
   wire nx_io = is_d ? req_io : is_e || (is_c && cp_port);
   wire nx_byte = is_d ? req_byte : is_c ? !cp_port && cp_odd : sel == src_pf && pf_addr_ff[0];
   wire [23:0] esc_addr = esc_port_sel ? CP_PORT_STAT : CP_PORT_CMD;
   wire [23:0] cp_addr = cp_port ? CP_PORT_DATA : cp_maddr;
   wire [23:0] nx_addr = is_d ? req_addr : is_e ? esc_addr : is_c ? cp_addr : pf_addr_ff;
   wire [15:0] nx_wdata = is_d ? req_wdata : is_e ? esc_wdata : cp_wdata;
   wire nx_lock = is_d ? req_lock : is_i;
   wire nx_drop = is_d ? req_lock_drop : is_i;
   wire [2:0] pf_bytes = pf_addr_ff[0] ? 3'h1 : 3'h2;
   wire pf_launch = launch && sel == src_pf;

   // bus state sequence, stepped once per processor cycle
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         s_idle: begin
            if (launch) begin
               nxt_state = s_status;
            end else if (hold_go) begin
               nxt_state = s_hold;
            end
         end
         s_status: begin
            nxt_state = s_cmd;
         end
         s_cmd: begin
            if (cmd_end) begin
               if (inta1_end) begin
                  nxt_state = s_gap;
               end else if (launch) begin
                  nxt_state = s_status;
               end else if (hold_go) begin
                  nxt_state = cur_write_ff ? s_hold_ti : s_hold;
               end else begin
                  nxt_state = s_idle;
               end
            end
         end
         s_hold_ti: begin
            nxt_state = s_hold;
         end
         s_hold: begin
            if (!hold_req) begin
               nxt_state = s_idle;
            end
         end
         s_gap: begin
            if (gap_cnt_ff == 2'h0) begin
               nxt_state = s_status;
            end
         end
         default: begin
            nxt_state = s_idle;
         end
      endcase
   end

   // phase and state registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ph2_ff <= 1'b0;
         state_ff <= s_idle;
         first_tc_ff <= 1'b0;
         wr_tail_ff <= 1'b0;
      end else begin
         ph2_ff <= !ph2_ff;
         if (adv) begin
            state_ff <= nxt_state;
            first_tc_ff <= state_ff == s_status;
            wr_tail_ff <= cmd_end && cur_write_ff;
         end
      end
   end

   // lock: set at the status state, dropped after the first command state
   wire drop_now = adv && state_ff == s_cmd && first_tc_ff && cur_drop_ff;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lock_ff <= 1'b0;
      end else if (launch) begin
         lock_ff <= nx_lock;
      end else if (gap_done) begin
         lock_ff <= 1'b1;
      end else if (drop_now) begin
         lock_ff <= 1'b0;
      end
   end

   // current operation latched when it starts
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cur_src_ff <= src_none;
         cur_write_ff <= 1'b0;
         cur_io_ff <= 1'b0;
         cur_byte_ff <= 1'b0;
         cur_drop_ff <= 1'b0;
         cur_hi_ff <= 1'b0;
         cur_wdata_ff <= 16'h0;
         addr_ff <= 24'h0;
      end else if (launch) begin
         cur_src_ff <= sel;
         cur_write_ff <= nx_write;
         cur_io_ff <= nx_io;
         cur_byte_ff <= nx_byte;
         cur_drop_ff <= nx_drop;
         cur_hi_ff <= cp_m[0] && !cp_port;
         cur_wdata_ff <= nx_wdata;
         addr_ff <= nx_addr;
      end else if (gap_done) begin
         cur_drop_ff <= 1'b1;
      end
   end

   // acknowledge sequence: gap counter and second-cycle marker
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gap_cnt_ff <= 2'h0;
         inta2_ff <= 1'b0;
      end else if (adv) begin
         if (inta1_end) begin
            gap_cnt_ff <= 2'(GAP_CYCLES - 1);
         end else if (state_ff == s_gap && gap_cnt_ff != 2'h0) begin
            gap_cnt_ff <= gap_cnt_ff - 2'h1;
         end
         if (gap_done) begin
            inta2_ff <= 1'b1;
         end else if (launch || hold_go) begin
            inta2_ff <= 1'b0;
         end
      end
   end

   // write data loaded on entry to phase two of the status state
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         data_out_ff <= 16'h0;
      end else if (state_ff == s_status && !ph2_ff && cur_write_ff) begin
         data_out_ff <= cur_wdata_ff;
      end
   end

   // coprocessor operand steps and data capture
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cp_step_ff <= 2'h0;
         cp_data_ff <= 16'h0;
      end else begin
         if (launch && is_c) begin
            cp_step_ff <= cp_last ? 2'h0 : cp_step_ff + 2'h1;
         end
         if (cyc_end && cur_src_ff == src_cp && !cur_write_ff) begin
            if (!cur_byte_ff) begin
               cp_data_ff <= data_in;
            end else if (cur_hi_ff) begin
               cp_data_ff[15:8] <= data_in[7:0];
            end else begin
               cp_data_ff[7:0] <= data_in[15:8];
            end
         end
      end
   end

   // prefetch queue accounting, counting bytes in flight
   wire [2:0] q_add = pf_launch ? pf_bytes : 3'h0;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q_cnt_ff <= 3'h0;
         pf_addr_ff <= 24'h0;
         pf_stop_ff <= 1'b0;
         cur_stale_ff <= 1'b0;
      end else if (ctl_xfer) begin
         q_cnt_ff <= 3'h0;
         pf_addr_ff <= ctl_target;
         pf_stop_ff <= pf_halt_stop; // a stop decoded in the same cycle wins
         cur_stale_ff <= 1'b1;
      end else begin
         q_cnt_ff <= q_cnt_ff + q_add - {1'b0, q_take};
         if (pf_launch) begin
            pf_addr_ff <= pf_addr_ff + {21'h0, pf_bytes};
            cur_stale_ff <= 1'b0;
         end
         if (pf_halt_stop) begin
            pf_stop_ff <= 1'b1;
         end
      end
   end

   // read results, fetched code, vector and execution limit fault
   wire rd_done = cyc_end && !cur_write_ff;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 16'h0;
         rd_valid <= 1'b0;
         fetch_data <= 16'h0;
         fetch_valid <= 1'b0;
         fetch_byte <= 1'b0;
         vector <= 8'h0;
         vector_valid <= 1'b0;
         gp_fault <= 1'b0;
      end else begin
         rd_valid <= rd_done && (cur_src_ff == src_data || cur_src_ff == src_esc);
         fetch_valid <= rd_done && cur_src_ff == src_pf && !cur_stale_ff && !ctl_xfer;
         vector_valid <= rd_done && cur_src_ff == src_interrupt_ack_cycle && inta2_ff;
         gp_fault <= exec_valid && prot_mode && exec_addr > cs_last_addr;
         if (rd_done) begin
            rd_data <= data_in;
            fetch_data <= data_in;
            fetch_byte <= cur_byte_ff;
            if (inta2_ff) begin
               vector <= data_in[7:0];
            end
         end
      end
   end

   // pin drive
   wire in_cyc = state_ff == s_status || state_ff == s_cmd;
   wire in_hold = state_ff == s_hold;
   wire addr_float = state_ff == s_gap || (inta2_ff && (state_ff == s_status ||
      (state_ff == s_cmd && first_tc_ff)));
   wire wr_drive = cur_write_ff && ((state_ff == s_status && ph2_ff) || state_ff == s_cmd);
   assign data_oe = !in_hold && (wr_drive || (wr_tail_ff && !ph2_ff));
   assign data_out = data_out_ff;
   assign bus_addr = addr_ff;
   assign addr_oe = !in_hold && !addr_float;
   assign status_oe = !in_hold;
   assign lock_oe = !in_hold;
   assign lock_b = !lock_ff;
   assign hold_grant = in_hold;
   assign transfer_direction = !(in_cyc && !cur_write_ff);
   assign interrupt_ack_cycle = in_cyc && cur_src_ff == src_interrupt_ack_cycle;
   assign mem_io = !cur_io_ff;

   // status lines carry the cycle type only in the status state
   wire [1:0] cyc_stat = cur_src_ff == src_interrupt_ack_cycle ? STAT_INTERRUPT_ACK_CYCLE :
      cur_write_ff ? STAT_WRITE : STAT_READ;
   assign status_b = state_ff == s_status ? cyc_stat : STAT_NONE;

endmodule

//--- dv/bus_cycle_ctrl_props.sv
// assertion checker for the local bus cycle controller
`timescale 1ns/1ps
module bus_cycle_ctrl_props
   import bus_cycle_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ready_b,
   input wire logic prot_mode,
   input wire logic exec_valid,
   input wire logic [23:0] exec_addr,
   input wire logic [23:0] cs_last_addr,
   input wire logic addr_oe,
   input wire logic data_oe,
   input wire logic [1:0] status_b,
   input wire logic status_oe,
   input wire logic transfer_direction,
   input wire logic lock_b,
   input wire logic hold_grant,
   input wire logic interrupt_ack_cycle,
   input wire logic rd_valid,
   input wire logic gp_fault
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // direction follows the status of the cycle
   property p_dir_rd; status_oe && status_b == STAT_READ |-> !transfer_direction; endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("direction high in read");
   property p_dir_wr; status_oe && status_b == STAT_WRITE |-> transfer_direction; endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("direction low in write");
   // write data starts only in the second half of the status state
   property p_wd_late; $rose(data_oe) |-> $past(status_oe) && $past(status_b) == STAT_WRITE;
   endproperty
   a_wd_late: assert property (p_wd_late) else $error("write data driven early");
   property p_wd_hold; $rose(data_oe) |-> data_oe [*4]; endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("write data dropped early");
   // hold state floats the address, data and status drivers
   property p_hold_fl; hold_grant |-> !addr_oe && !data_oe && !status_oe; endproperty
   a_hold_fl: assert property (p_hold_fl) else $error("driver active in hold");
   property p_hold_gap; $rose(hold_grant) |-> !$past(data_oe); endproperty
   a_hold_gap: assert property (p_hold_gap) else $error("grant without idle cycle");
   property p_ack_nh; $rose(hold_grant) |-> $past(addr_oe); endproperty
   a_ack_nh: assert property (p_ack_nh) else $error("grant inside acknowledge");
   property p_lock_nh; !lock_b |-> !hold_grant; endproperty
   a_lock_nh: assert property (p_lock_nh) else $error("grant while locked");
   property p_ack_lk; status_oe && status_b == STAT_INTERRUPT_ACK_CYCLE |-> !lock_b; endproperty
   a_ack_lk: assert property (p_ack_lk) else $error("acknowledge status unlocked");
   property p_rd_rdy; rd_valid |-> !$past(ready_b) || !$past(ready_b, 2); endproperty
   a_rd_rdy: assert property (p_rd_rdy) else $error("read ended without ready");
   property p_gp;
      gp_fault |-> $past(exec_valid) && $past(prot_mode) && $past(exec_addr) > $past(cs_last_addr);
   endproperty
   a_gp: assert property (p_gp) else $error("fault without overrun");
endmodule
bind bus_cycle_ctrl bus_cycle_ctrl_props props (.clk_sys(clk_sys), .rst_b(rst_b),
   .ready_b(ready_b), .prot_mode(prot_mode), .exec_valid(exec_valid), .exec_addr(exec_addr),
   .cs_last_addr(cs_last_addr), .addr_oe(addr_oe), .data_oe(data_oe), .status_b(status_b),
   .status_oe(status_oe), .transfer_direction(transfer_direction), .lock_b(lock_b),
   .hold_grant(hold_grant), .interrupt_ack_cycle(interrupt_ack_cycle), .rd_valid(rd_valid),
   .gp_fault(gp_fault));

//--- dv/bus_ready_model.sv
// ready generator and read responder at the far side of the local bus
`timescale 1ns/1ps
module bus_ready_model
   import bus_cycle_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [1:0] status_b,
   input wire logic status_oe,
   input wire logic [1:0] waits,
   input wire logic [15:0] resp,
   output logic ready_b,
   output logic [15:0] data_in
);
   logic [3:0] cnt_ff;
   logic busy_ff, ack_ff, prev_ff;
   wire st_on = status_oe && status_b != STAT_NONE;
   // extra wait forced on acknowledge cycles
   wire [3:0] lim = 4'h2 + {1'b0, waits, 1'b0} + {2'h0, ack_ff, 1'b0};
   // ready low only through the last command state
   assign ready_b = !(busy_ff && cnt_ff >= lim);
   // bus shows the inverse pattern outside the answer
   assign data_in = ready_b ? ~resp : resp;
   // cycle tracker
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 4'h0;
         busy_ff <= 1'b0;
         ack_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= st_on;
         if (st_on && !prev_ff) begin
            cnt_ff <= 4'h1;
            busy_ff <= 1'b1;
            ack_ff <= status_b == STAT_INTERRUPT_ACK_CYCLE;
         end else if (busy_ff && !ready_b && cnt_ff[0]) begin
            busy_ff <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end
endmodule

//--- dv/bus_cycle_ctrl_tb.sv
// self-checking bench for the local bus cycle controller
`timescale 1ns/1ps
module bus_cycle_ctrl_tb
   import bus_cycle_pkg::*;
;
   typedef struct packed {
      logic w; logic io; logic lk; logic dr; logic [1:0] ws; logic [23:0] a; logic [15:0] d;
   } row_t;
   logic clk_sys = 1'b0, rst_b = 1'b0, hold_req = 1'b0, interrupt_request = 1'b0;
   logic req_valid = 1'b0, req_write = 1'b0, req_io = 1'b0, req_lock = 1'b0;
   logic req_lock_drop = 1'b0, esc_valid = 1'b0, esc_port_sel = 1'b0, esc_write = 1'b0;
   logic coproc_operand_request = 1'b0, coproc_escape_op = 1'b0, emulation_bit = 1'b0;
   logic ctl_xfer = 1'b0, pf_halt_stop = 1'b0, prot_mode = 1'b0, exec_valid = 1'b0;
   logic [23:0] req_addr = 24'h0, ctl_target = 24'h0, cp_mem_addr = 24'h0;
   logic [23:0] cs_last_addr = 24'h0, exec_addr = 24'h0, last_addr = 24'h0;
   logic [15:0] req_wdata = 16'h0, resp = 16'h0;
   logic [1:0] ws = 2'h0;
   logic [1:0] q_take = 2'h0;
   logic [7:0] n_cyc = 8'h0, n_interrupt_ack_cycle = 8'h0, n_fetch = 8'h0, n_esc = 8'h0;
   logic st_prev = 1'b0, saw_fa = 1'b0;
   int bad_count = 0, num_checks = 0;
   wire ready_b, addr_oe, data_oe, status_oe, mem_io, interrupt_ack_cycle, transfer_direction;
   wire lock_b, lock_oe, hold_grant, req_ready, esc_ready, rd_valid, fetch_valid, fetch_byte;
   wire vector_valid, gp_fault;
   wire [15:0] data_in, data_out, rd_data, fetch_data;
   wire [23:0] bus_addr;
   wire [7:0] vector;
   wire [1:0] status_b;
   wire [7:0] evt = {interrupt_ack_cycle, gp_fault, esc_ready, req_ready, fetch_valid,
      hold_grant, vector_valid, rd_valid};
   wire st_on = status_oe && status_b != STAT_NONE;
   row_t rows [4] = '{'{1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 24'h000400, 16'h1234},
      '{1'b0, 1'b0, 1'b1, 1'b1, 2'h1, 24'h000402, 16'hbeef},
      '{1'b1, 1'b1, 1'b0, 1'b0, 2'h2, 24'h000080, 16'h00ff},
      '{1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 24'h000082, 16'h7e81}};
   bus_cycle_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .ready_b(ready_b),
      .hold_req(hold_req), .interrupt_request(interrupt_request), .req_valid(req_valid),
      .req_write(req_write), .req_io(req_io), .req_byte(1'b0), .req_lock(req_lock),
      .req_lock_drop(req_lock_drop), .req_addr(req_addr), .req_wdata(req_wdata),
      .esc_valid(esc_valid), .esc_port_sel(esc_port_sel), .esc_write(esc_write),
      .esc_wdata(16'h5a5a), .coproc_operand_request(coproc_operand_request),
      .coproc_escape_op(coproc_escape_op), .cp_store(1'b0), .cp_mem_addr(cp_mem_addr),
      .emulation_bit(emulation_bit), .task_switched_bit(1'b0), .q_take(q_take),
      .ctl_xfer(ctl_xfer), .ctl_target(ctl_target), .pf_halt_stop(pf_halt_stop),
      .prot_mode(prot_mode), .cs_last_addr(cs_last_addr), .exec_valid(exec_valid),
      .exec_addr(exec_addr), .data_in(data_in), .bus_addr(bus_addr), .addr_oe(addr_oe),
      .data_out(data_out), .data_oe(data_oe), .status_b(status_b), .status_oe(status_oe),
      .mem_io(mem_io), .interrupt_ack_cycle(interrupt_ack_cycle),
      .transfer_direction(transfer_direction), .lock_b(lock_b), .lock_oe(lock_oe),
      .hold_grant(hold_grant), .req_ready(req_ready), .esc_ready(esc_ready),
      .rd_data(rd_data), .rd_valid(rd_valid), .fetch_data(fetch_data),
      .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .vector(vector),
      .vector_valid(vector_valid), .gp_fault(gp_fault));
   bus_ready_model partner (.clk_sys(clk_sys), .rst_b(rst_b), .status_b(status_b),
      .status_oe(status_oe), .waits(ws), .resp(resp), .ready_b(ready_b), .data_in(data_in));
   always #10 clk_sys = ~clk_sys;
   // bus activity counters
   always @(posedge clk_sys) begin
      st_prev <= st_on;
      if (st_on && !st_prev) begin
         n_cyc <= n_cyc + 8'h1;
         last_addr <= bus_addr;
         if (status_b == STAT_INTERRUPT_ACK_CYCLE) n_interrupt_ack_cycle <= n_interrupt_ack_cycle + 8'h1;
         if (bus_addr == CP_PORT_DATA && !mem_io) saw_fa <= 1'b1;
      end
      if (fetch_valid) n_fetch <= n_fetch + 8'h1;
      if (esc_ready) n_esc <= n_esc + 8'h1;
   end
   task automatic wrap_up();
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // bounded wait on one completion event
   task automatic wait_on(input int k, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(negedge clk_sys);
         if (evt[k] === 1'b1) break;
      end
      if (i == lim) begin
         chk("wait", 24'(k), 24'hffffff);
         wrap_up();
      end
   endtask
   task automatic data_req(input row_t r);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= r.w;
      req_io <= r.io;
      req_lock <= r.lk;
      req_lock_drop <= r.dr;
      req_addr <= r.a;
      req_wdata <= r.d;
      ws <= r.ws;
      resp <= r.d;
      wait_on(4, 200);
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      chk("reset", {status_b, data_oe, lock_b, hold_grant, transfer_direction}, 6'h35);
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      wait_on(3, 100);
      chk("word fetch", fetch_byte, 1'b0);
      for (int i = 0; i < 4; i++) begin
         data_req(rows[i]);
         @(negedge clk_sys);
         if (rows[i].w) begin
            @(negedge clk_sys);
            chk("wdata", data_out, rows[i].d);
            chk("wdrive", {data_oe, transfer_direction}, 2'h3);
         end else begin
            wait_on(0, 100);
            chk("rdata", rd_data, rows[i].d);
         end
      end
      data_req(rows[2]);
      hold_req <= 1'b1;
      wait_on(2, 100);
      chk("hold", {addr_oe, data_oe, status_oe}, 3'h0);
      @(posedge clk_sys);
      hold_req <= 1'b0;
      resp <= 16'h3c5a;
      ws <= 2'h0;
      interrupt_request <= 1'b1;
      wait_on(7, 200);
      @(posedge clk_sys);
      interrupt_request <= 1'b0;
      hold_req <= 1'b1;
      wait_on(1, 200);
      chk("vector", vector, 8'h5a);
      chk("acks", n_interrupt_ack_cycle, 8'h2);
      wait_on(2, 100);
      @(posedge clk_sys);
      hold_req <= 1'b0;
      prot_mode <= 1'b1;
      cs_last_addr <= 24'h0000ff;
      exec_addr <= 24'h000100;
      exec_valid <= 1'b1;
      @(posedge clk_sys);
      exec_valid <= 1'b0;
      wait_on(6, 10);
      @(posedge clk_sys);
      prot_mode <= 1'b0;
      ctl_xfer <= 1'b1;
      ctl_target <= 24'h000301;
      @(posedge clk_sys);
      ctl_xfer <= 1'b0;
      wait_on(3, 100);
      chk("byte fetch", fetch_byte, 1'b1);
      // let the queue fill, then free room that only a stopped fetcher leaves unused
      repeat (40) @(negedge clk_sys);
      n_fetch = 8'h0;
      @(posedge clk_sys);
      pf_halt_stop <= 1'b1;
      @(posedge clk_sys);
      pf_halt_stop <= 1'b0;
      q_take <= 2'h2;
      @(posedge clk_sys);
      q_take <= 2'h0;
      repeat (60) @(negedge clk_sys);
      chk("stopped", n_fetch, 8'h0);
      @(posedge clk_sys);
      esc_valid <= 1'b1;
      esc_port_sel <= 1'b1;
      esc_write <= 1'b1;
      emulation_bit <= 1'b1;
      repeat (30) @(negedge clk_sys);
      chk("esc refused", n_esc, 8'h0);
      @(posedge clk_sys);
      emulation_bit <= 1'b0;
      wait_on(5, 100);
      @(posedge clk_sys);
      esc_valid <= 1'b0;
      repeat (20) @(negedge clk_sys);
      chk("esc port", last_addr, CP_PORT_STAT);
      n_cyc = 8'h0;
      @(posedge clk_sys);
      coproc_escape_op <= 1'b1;
      coproc_operand_request <= 1'b1;
      cp_mem_addr <= 24'h000501;
      repeat (3) @(posedge clk_sys);
      coproc_operand_request <= 1'b0;
      repeat (80) @(negedge clk_sys);
      chk("cp cycles", n_cyc, 8'h3);
      chk("cp port", saw_fa, 1'b1);
      wrap_up();
   end
endmodule
